// [logic/spc_regs.sv]
// serial control port and its configuration, identification and
// readback-select registers, plus one buffered control register
// assumes sclk slow against clk (at least ten clk per sclk half)
`timescale 1ns/1ps
module spc_regs #(
    parameter logic [7:0] VARIANT_CODE = spc_pkg::VARIANT_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        data_pin_i,
    output spc_pkg::spc_pins_t pins,
    output spc_pkg::spc_cfg_t  cfg,
    output logic [7:0]       sys_ctrl_active
);
    import spc_pkg::*;
    // every check below runs on clk and sleeps through reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [SYNC_DEPTH-1:0] sync_reg [PIN_COUNT];
    logic [PIN_COUNT-1:0]  pin_in;
    logic [PIN_COUNT-1:0]  stable_reg;
    logic                  sclk_prev_reg;
    logic                  rise;
    spc_state_t            state_reg;
    logic [3:0]            bit_cnt_reg;
    logic [15:0]           instr_sr_reg;
    logic [15:0]           instr_next;
    logic [7:0]            byte_sr_reg;
    logic [7:0]            byte_next;
    logic [ADDR_W-1:0]     addr_reg;
    logic [ADDR_W-1:0]     addr_step;
    logic [ADDR_W-1:0]     rd_addr;
    logic                  rw_reg;
    logic                  stream_reg;
    logic [1:0]            bytes_left_reg;
    logic                  byte_end;
    logic                  instr_end;
    logic                  load_rd;
    logic [7:0]            rd_byte_reg;
    logic                  wr_en_reg;
    logic [ADDR_W-1:0]     wr_addr_reg;
    logic [7:0]            wr_data_reg;
    spc_cfg_t              cfg_reg;
    logic [7:0]            rb_reg;
    logic [7:0]            sys_buf_reg;
    logic [7:0]            sys_act_reg;
    spc_pins_t             pins_reg;
    logic [2:0]            out_idx;
    logic                  rd_phase;
    assign pin_in = {sclk_i, cs_n_i, data_pin_i};
    // three-stage sync; a change counts once stages two and three agree
    // stages reset high so chip select is not seen low after reset
    for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                sync_reg[gi]   <= '1;
                stable_reg[gi] <= 1'b1;
            end else begin
                sync_reg[gi] <= {sync_reg[gi][SYNC_DEPTH-2:0],
                                 pin_in[gi]};
                if (sync_reg[gi][1] == sync_reg[gi][2]) begin
                    stable_reg[gi] <= sync_reg[gi][2];
                end
            end
        end
    end
    // sclk edge detect on the filtered level only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= stable_reg[2];
        end
    end
    assign rise        = stable_reg[2] & ~sclk_prev_reg;
    // shift direction follows bit order; both land the same word
    always_comb begin
        if (cfg_reg.lsb_first) begin
            instr_next = {stable_reg[0], instr_sr_reg[15:1]};
            byte_next  = {stable_reg[0], byte_sr_reg[7:1]};
            addr_step  = addr_reg + ADDR_STEP;
        end else begin
            instr_next = {instr_sr_reg[14:0], stable_reg[0]};
            byte_next  = {byte_sr_reg[6:0], stable_reg[0]};
            addr_step  = addr_reg - ADDR_STEP;
        end
    end
    assign instr_end = rise && state_reg == SPC_INSTR
                       && bit_cnt_reg == INSTR_LAST;
    assign byte_end  = rise && state_reg == SPC_DATA
                       && bit_cnt_reg == BYTE_LAST;
    assign load_rd   = instr_end || byte_end;
    assign rd_addr   = instr_end ? instr_next[ADDR_W-1:0] : addr_step;
    // frame sequencer; every instruction is 16 bits long
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg      <= SPC_IDLE;
            bit_cnt_reg    <= '0;
            instr_sr_reg   <= '0;
            byte_sr_reg    <= '0;
            addr_reg       <= '0;
            rw_reg         <= 1'b0;
            stream_reg     <= 1'b0;
            bytes_left_reg <= '0;
        end else if (stable_reg[1]) begin
            state_reg   <= SPC_IDLE;
            bit_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                SPC_IDLE: state_reg <= SPC_INSTR; // count already zero
                SPC_INSTR: if (rise) begin
                    instr_sr_reg <= instr_next;
                    bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                    if (instr_end) begin
                        state_reg      <= SPC_DATA;
                        addr_reg       <= instr_next[ADDR_W-1:0];
                        rw_reg         <= instr_next[INSTR_RW_BIT];
                        stream_reg     <= instr_next[INSTR_W_HI:INSTR_W_LO]
                                          == W_STREAM;
                        bytes_left_reg <= instr_next[INSTR_W_HI:INSTR_W_LO];
                        bit_cnt_reg    <= '0;
                    end
                end
                SPC_DATA: if (rise) begin
                    byte_sr_reg <= byte_next;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (byte_end) begin
                        bit_cnt_reg    <= '0;
                        addr_reg       <= addr_step;
                        bytes_left_reg <= bytes_left_reg - W_STEP;
                        if (!stream_reg && bytes_left_reg == '0) begin
                            state_reg <= SPC_DONE;
                        end
                    end
                end
                SPC_DONE: bit_cnt_reg <= '0;
            endcase
        end
    end
    // write strobe one cycle after the byte completes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else begin
            wr_en_reg   <= byte_end && !rw_reg;
            wr_addr_reg <= addr_reg;
            wr_data_reg <= byte_next;
        end
    end
    // port config; length bit and its mirror cannot be cleared
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= CFG_RESET;
        end else if (wr_en_reg && wr_addr_reg == ADDR_PORT_CFG) begin
            cfg_reg            <= wr_data_reg;
            cfg_reg.long_instr <= 1'b1;
            cfg_reg.mirror[0]  <= 1'b1;
        end
    end
    // soft reset holds the other registers at default while set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rb_reg      <= RB_RESET;
            sys_buf_reg <= SYS_CTRL_RESET;
            sys_act_reg <= SYS_CTRL_RESET;
        end else if (cfg_reg.soft_reset) begin
            rb_reg      <= RB_RESET;
            sys_buf_reg <= SYS_CTRL_RESET;
            sys_act_reg <= SYS_CTRL_RESET;
        end else if (wr_en_reg) begin
            // variant code has no write path, writes fall through
            unique case (wr_addr_reg)
                ADDR_READBACK: rb_reg      <= wr_data_reg;
                ADDR_SYS_CTRL: sys_buf_reg <= wr_data_reg;
                ADDR_UPDATE: if (wr_data_reg[UPD_BIT]) begin
                    sys_act_reg <= sys_buf_reg;
                end
                default: ;
            endcase
        end
    end
    // read mux; update bit is never stored so reads back zero
    function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_PORT_CFG: return cfg_reg;
            ADDR_VARIANT:  return VARIANT_CODE;
            ADDR_READBACK: return rb_reg;
            ADDR_SYS_CTRL: return rb_reg[RB_BIT_ACTIVE] ? sys_act_reg
                                                        : sys_buf_reg;
            default:       return '0;
        endcase
    endfunction
    // read byte captured at each byte boundary
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_byte_reg <= '0;
        end else if (load_rd) begin
            rd_byte_reg <= read_mux(rd_addr);
        end
    end
    assign out_idx  = cfg_reg.lsb_first ? bit_cnt_reg[2:0]
                                        : BYTE_MSB - bit_cnt_reg[2:0];
    assign rd_phase = state_reg == SPC_DATA && rw_reg && !stable_reg[1];
    // pin drive; output select chooses which pin carries reads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_reg <= '0;
        end else begin
            pins_reg.data_o  <= rd_byte_reg[out_idx];
            pins_reg.ser_o   <= rd_byte_reg[out_idx];
            pins_reg.data_oe <= rd_phase && !cfg_reg.sep_out;
            pins_reg.ser_oe  <= rd_phase && cfg_reg.sep_out;
        end
    end
    assign pins            = pins_reg;
    assign cfg             = cfg_reg;
    assign sys_ctrl_active = sys_act_reg;
    // checks use the default clock and reset declared at the top
    property p_long_kept;
        cfg_reg.long_instr && cfg_reg.mirror[0];
    endproperty
    a_long_kept: assert property (p_long_kept)
        else $error("long instruction bit lost");
    property p_soft_defaults;
        cfg_reg.soft_reset |=> rb_reg == RB_RESET
            && sys_buf_reg == SYS_CTRL_RESET;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults)
        else $error("soft reset did not restore defaults");
    property p_soft_sticky;
        cfg_reg.soft_reset && !(wr_en_reg && wr_addr_reg == ADDR_PORT_CFG)
            |=> cfg_reg.soft_reset;
    endproperty
    a_soft_sticky: assert property (p_soft_sticky)
        else $error("soft reset cleared itself");
    property p_addr_dec;
        byte_end && !cfg_reg.lsb_first
            |=> addr_reg == $past(addr_reg) - ADDR_STEP;
    endproperty
    a_addr_dec: assert property (p_addr_dec)
        else $error("address did not decrement");
    property p_addr_inc;
        byte_end && cfg_reg.lsb_first
            |=> addr_reg == $past(addr_reg) + ADDR_STEP;
    endproperty
    a_addr_inc: assert property (p_addr_inc)
        else $error("address did not increment");
    property p_bidir;
        !cfg_reg.sep_out && !$past(cfg_reg.sep_out) |-> !pins_reg.ser_oe;
    endproperty
    a_bidir: assert property (p_bidir)
        else $error("separate output driven in bidirectional mode");
    property p_sep;
        cfg_reg.sep_out && $past(cfg_reg.sep_out) |-> !pins_reg.data_oe;
    endproperty
    a_sep: assert property (p_sep)
        else $error("data pin driven in separate output mode");
    property p_variant;
        load_rd && rd_addr == ADDR_VARIANT |=> rd_byte_reg == VARIANT_CODE;
    endproperty
    a_variant: assert property (p_variant)
        else $error("variant code misread");
    property p_readback;
        load_rd && rd_addr == ADDR_SYS_CTRL |=> rd_byte_reg ==
            ($past(rb_reg[RB_BIT_ACTIVE]) ? $past(sys_act_reg)
                                          : $past(sys_buf_reg));
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback bank wrong");
    property p_update;
        wr_en_reg && wr_addr_reg == ADDR_UPDATE && wr_data_reg[UPD_BIT]
            && !cfg_reg.soft_reset |=> sys_act_reg == $past(sys_buf_reg);
    endproperty
    a_update: assert property (p_update)
        else $error("update did not transfer buffer");
    property p_variant_wr;
        wr_en_reg && wr_addr_reg == ADDR_VARIANT && !cfg_reg.soft_reset
            |=> $stable(cfg_reg) && $stable(rb_reg)
                && $stable(sys_buf_reg) && $stable(sys_act_reg);
    endproperty
    a_variant_wr: assert property (p_variant_wr)
        else $error("write to variant code changed state");

endmodule

// [logic/spc_pkg.sv]
// constants, field layouts and carrier types of the serial port
// configuration register bank; shared by the bank and its bench
package spc_pkg;

    // register addresses, 13-bit instruction address field
    localparam int          ADDR_W         = 13;
    localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
    localparam logic [12:0] ADDR_VARIANT   = 13'h0003;
    localparam logic [12:0] ADDR_READBACK  = 13'h0004;
    localparam logic [12:0] ADDR_SYS_CTRL  = 13'h0230;
    localparam logic [12:0] ADDR_UPDATE    = 13'h0232;
    localparam logic [12:0] ADDR_STEP      = 13'h0001;

    // reset values; long instruction bit and its mirror set
    localparam logic [7:0]  CFG_RESET      = 8'h18;
    localparam logic [7:0]  RB_RESET       = 8'h00;
    localparam logic [7:0]  SYS_CTRL_RESET = 8'h00;
    // arbitrary neutral identification value
    localparam logic [7:0]  VARIANT_DEFAULT = 8'h5A;

    // field positions
    localparam int          RB_BIT_ACTIVE  = 0;
    localparam int          UPD_BIT        = 0;

    // instruction word layout and counts
    localparam int          INSTR_RW_BIT   = 15;
    localparam int          INSTR_W_HI     = 14;
    localparam int          INSTR_W_LO     = 13;
    localparam logic [3:0]  INSTR_LAST     = 4'hF;
    localparam logic [3:0]  BYTE_LAST      = 4'h7;
    localparam logic [2:0]  BYTE_MSB       = 3'h7;
    localparam logic [1:0]  W_STREAM       = 2'h3;
    localparam logic [1:0]  W_STEP         = 2'h1;
    localparam int          SYNC_DEPTH     = 3;
    localparam int          PIN_COUNT      = 3;

    // port configuration byte
    typedef struct packed {
        logic [3:0] mirror;
        logic       long_instr;
        logic       soft_reset;
        logic       lsb_first;
        logic       sep_out;
    } spc_cfg_t;

    // serial pin drive
    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic ser_o;
        logic ser_oe;
    } spc_pins_t;

    typedef enum logic [1:0] {
        SPC_IDLE,
        SPC_INSTR,
        SPC_DATA,
        SPC_DONE
    } spc_state_t;

endpackage

// [tb/spc_host.sv]
// serial host controller model driving the control port frames
// assumes a 250 MHz clk; data wire level is resolved by the bench
`timescale 1ns/1ps

module spc_host
    import spc_pkg::*;
(
    input  wire logic          clk,
    input  spc_pkg::spc_pins_t pins,
    input  wire logic          dpin,
    output logic               sclk_o,
    output logic               cs_n_o,
    output logic               d_o,
    output logic               d_oe
);
    logic lsb = 1'b0;
    logic sep = 1'b0;
    logic rel = 1'b0;

    // idle: serial clock parked low, chip select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        d_o    = 1'b1;
        d_oe   = 1'b0;
    end

    // half period of 12 clk keeps above the 10 clk read turnaround
    task automatic half;
        repeat (12) @(posedge clk);
        #1;
    endtask

    // one bit; a released wire toggles so a silent device shows up
    task automatic shift(input logic b, input logic drv, output logic s);
        d_oe   = drv;
        d_o    = drv ? b : ~d_o;
        sclk_o = 1'b0;
        half();
        // a released separate pin shows the inverse of its last level
        s      = sep ? (pins.ser_oe ? pins.ser_o : ~pins.ser_o) : dpin;
        sclk_o = 1'b1;
        // let go of the data wire before the device starts to answer
        if (rel) d_oe = 1'b0;
        half();
    endtask

    // one frame of up to four bytes in the current bit order
    task automatic xfer(input logic rd, input logic [1:0] w,
                        input logic [12:0] a, input logic [31:0] wd,
                        output logic [31:0] rv);
        logic [15:0] ins;
        logic        s;
        int          n;
        int          k;
        ins = {rd, w, a};
        rv  = '0;
        n   = 8 * (int'(w) + 1);
        @(posedge clk);
        #1;
        cs_n_o = 1'b0;
        half();
        // always the long sixteen bit instruction
        for (int i = 0; i < 16; i++) begin
            rel = rd && i == 15;
            shift(ins[lsb ? i : 15 - i], 1'b1, s);
        end
        rel = 1'b0;
        for (int i = 0; i < n; i++) begin
            k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
            shift(wd[k], !rd, s);
            rv[k] = s;
        end
        sclk_o = 1'b0;
        half();
        cs_n_o = 1'b1;
        d_oe   = 1'b0;
        half();
        half();
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench of the port configuration register bank
// assumes the host model above as the only register access path
`timescale 1ns/1ps

module tb;
    import spc_pkg::*;
    localparam logic [7:0] VC = 8'h3C; // arbitrary neutral code

    logic        clk;
    logic        sys_rst;
    logic        sclk;
    logic        cs_n;
    logic        d_o;
    logic        d_oe;
    logic        dpin;
    spc_pins_t   pins;
    spc_cfg_t    cfg;
    logic [7:0]  act;
    logic [31:0] rv;
    logic        ser_seen;
    logic        dat_seen;
    logic        clash;
    int          fails;
    int          tests_run;

    // device output wins while enabled, else the host side
    assign dpin = pins.data_oe ? pins.data_o : d_o;

    spc_regs #(.VARIANT_CODE(VC)) i_dut (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .sclk_i          (sclk),
        .cs_n_i          (cs_n),
        .data_pin_i      (dpin),
        .pins            (pins),
        .cfg             (cfg),
        .sys_ctrl_active (act)
    );

    spc_host i_host (
        .clk    (clk),
        .pins   (pins),
        .dpin   (dpin),
        .sclk_o (sclk),
        .cs_n_o (cs_n),
        .d_o    (d_o),
        .d_oe   (d_oe)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // sticky record of which output pin was ever enabled
    always @(posedge clk) begin
        ser_seen <= ser_seen | pins.ser_oe;
        dat_seen <= dat_seen | pins.data_oe;
        clash    <= clash | (d_oe & pins.data_oe);
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, 2'h0, a, {24'h0, d}, rv);
    endtask

    task automatic rd(input logic [12:0] a, input logic [1:0] w);
        i_host.xfer(1'b1, w, a, 32'h0, rv);
    endtask

    task automatic clr_seen;
        ser_seen = 1'b0;
        dat_seen = 1'b0;
        clash    = 1'b0;
    endtask

    // a hung frame ends the run as a failure
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        fails     = 0;
        tests_run = 0;
        sys_rst   = 1'b1;
        clr_seen();
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("cfg reset", {24'h0, cfg}, 32'h18);
        chk("active reset", {24'h0, act}, 32'h0);
        chk("pins reset", {28'h0, pins}, 32'h0);
        // identification read in bidirectional mode
        rd(ADDR_VARIANT, 2'h0);
        chk("variant", rv, {24'h0, VC});
        chk("ser oe bidir", {31'h0, ser_seen}, 32'h0);
        chk("data oe bidir", {31'h0, dat_seen}, 32'h1);
        wr(ADDR_VARIANT, 8'hFF);
        rd(ADDR_VARIANT, 2'h0);
        chk("variant kept", rv, {24'h0, VC});
        // buffered register against its active copy
        wr(ADDR_SYS_CTRL, 8'h55);
        chk("active before update", {24'h0, act}, 32'h0);
        rd(ADDR_SYS_CTRL, 2'h0);
        chk("buffer read", rv, 32'h55);
        wr(ADDR_READBACK, 8'h01);
        rd(ADDR_SYS_CTRL, 2'h0);
        chk("active read", rv, 32'h0);
        wr(ADDR_UPDATE, 8'h01);
        chk("active updated", {24'h0, act}, 32'h55);
        rd(ADDR_UPDATE, 2'h0);
        chk("update self clear", rv, 32'h0);
        rd(ADDR_SYS_CTRL, 2'h0);
        chk("active after update", rv, 32'h55);
        // two bytes msb first walk downwards
        rd(ADDR_READBACK, 2'h1);
        chk("descending pair", rv, {16'h0, VC, 8'h01});
        // mirrored values read alike in either order
        wr(ADDR_PORT_CFG, 8'h5A);
        i_host.lsb = 1'b1;
        chk("cfg lsb first", {24'h0, cfg}, 32'h5A);
        rd(ADDR_VARIANT, 2'h1);
        chk("ascending pair", rv, {16'h0, 8'h01, VC});
        // separate output pin carries read data
        wr(ADDR_PORT_CFG, 8'hDB);
        i_host.sep = 1'b1;
        clr_seen();
        rd(ADDR_VARIANT, 2'h0);
        chk("variant sep", rv, {24'h0, VC});
        chk("data oe sep", {31'h0, dat_seen}, 32'h0);
        chk("ser oe sep", {31'h0, ser_seen}, 32'h1);
        // a short instruction request is not taken
        wr(ADDR_PORT_CFG, 8'hC3);
        chk("long bit held", {24'h0, cfg}, 32'hDB);
        // soft reset holds until the host clears it
        wr(ADDR_PORT_CFG, 8'hFF);
        repeat (50) @(posedge clk);
        #1;
        chk("soft reset held", {24'h0, cfg}, 32'hFF);
        chk("active cleared", {24'h0, act}, 32'h0);
        wr(ADDR_SYS_CTRL, 8'h77);
        wr(ADDR_PORT_CFG, 8'hDB);
        rd(ADDR_READBACK, 2'h0);
        chk("select default", rv, 32'h0);
        rd(ADDR_SYS_CTRL, 2'h0);
        chk("buffer default", rv, 32'h0);
        chk("no contention", {31'h0, clash}, 32'h0);
        wrap_up();
    end
endmodule
